// ---- sre_map.vh ----
/*
 Constants for the read-side command engine of the two-wire serial memory.
 Assumes inclusion by sre_read_engine.v and sre_bit_slicer.v only.
*/
`ifndef SRE_MAP_VH
`define SRE_MAP_VH

`define SRE_ADDR_W        18
`define SRE_TYPE_MEM      4'ha
`define SRE_TYPE_ID       4'hb
`define SRE_ERASED_BYTE   8'hff
`define SRE_ADDR_ZERO     18'h0_0000
`define SRE_ACK_SLOT      4'h8
`define SRE_LAST_BIT      4'h7
`define SRE_BIT_PRE       4'hf
`define SRE_ID_DEPTH      256

`endif

// ---- sre_bit_slicer.v ----
/*
 Bus condition detector for the two-wire link.
 Assumes scl and sda inputs already synchronous to clk.
*/
`include "sre_map.vh"

module sre_bit_slicer (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       scl_i,
   input  wire       sda_i,
   output wire       scl_rise,
   output wire       scl_fall,
   output wire       start_det,
   output wire       stop_det
);
   reg scl_q;
   reg sda_q;

   // Previous line levels for edge and condition detection
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   // Data changing while clock is high marks Start or Stop
   assign scl_rise  = scl_i & ~scl_q;
   assign scl_fall  = ~scl_i & scl_q;
   assign start_det = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_det  = scl_i & scl_q & ~sda_q & sda_i;
endmodule // sre_bit_slicer

// ---- sre_read_engine.v ----
/*
 Read-side command engine of a two-wire serial memory target.
 Assumes the bus wires arrive synchronous to clk; sda is open drain.
*/
// Function
// (RULE1) Master loads address by dummy write first
// (RULE2) Repeated start, read select, drive addressed byte
// (RULE3) Master ends single read with NoAck, Stop
// (RULE4) Read select alone reads counter, then increments
// (RULE5) Array and ID page share one counter
// (RULE6) Master should prefer random over current reads
// (RULE7) Master ack keeps next bytes flowing
// (RULE8) Master ends sequential read with NoAck, Stop
// (RULE9) Counter advances per byte, wraps to zero
// (RULE10) ID page read uses 1011b, low byte offset
// (RULE11) Master must not read past ID page
// (RULE12) Lock query data byte acked only unlocked
// (RULE13) Start after lock query resets logic
// (RULE14) Stop returns device to standby
// (RULE15) All memory initially reads all ones
// (RULE16) No ack on ninth slot means standby
// (RULE17) Address is 18 bits, top two from select
// (RULE18) Dummy write acks two address bytes, MSB first
`include "sre_map.vh"

module sre_read_engine #(
   parameter ADDR_W   = `SRE_ADDR_W,
   parameter MEM_WORDS = 1024,
   parameter [2:0] CHIP_SEL = 3'h0
) (
   input  wire       clk,
   input  wire       rstn,
   input  wire       scl_i,
   input  wire       sda_i,
   output reg        sda_o,
   output wire       sda_oe_n,
   input  wire       id_locked,
   output wire [17:0] addr_cnt
);
   // One-hot protocol states
   localparam ST_IDLE = 6'h01;
   localparam ST_DEV  = 6'h02;
   localparam ST_AHI  = 6'h04;
   localparam ST_ALO  = 6'h08;
   localparam ST_DIN  = 6'h10;
   localparam ST_DOUT = 6'h20;
   // Index width of the modelled array
   localparam MEM_AW  = $clog2(MEM_WORDS);

   reg        rs1_q, rst_n;
   wire       scl_rise, scl_fall, start_det, stop_det;
   reg  [5:0] st_q;
   reg  [3:0] bit_q;
   reg  [7:0] sh_q;
   reg  [7:0] dout_q;
   reg  [17:0] cnt_q;
   reg  [1:0] top_q;
   reg        id_sel_q;
   reg        ack_q;
   reg        ack_drv_q;
   reg  [7:0] mem [0:MEM_WORDS-1];
   reg  [7:0] idp [0:`SRE_ID_DEPTH-1];
   integer    i;

   // Reset release through two flops
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rs1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rst_n <= rs1_q;
      end
   end

   sre_bit_slicer u_slice (
      .clk       (clk),
      .rst_n     (rst_n),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det)
   );

   // Erased content; storage only, the write path is outside this block
   initial begin
      for (i = 0; i < MEM_WORDS; i = i + 1)
         mem[i] = `SRE_ERASED_BYTE;                     // [RULE15]
      for (i = 0; i < `SRE_ID_DEPTH; i = i + 1)
         idp[i] = `SRE_ERASED_BYTE;                     // [RULE15]
   end

   assign addr_cnt = cnt_q;
   // Open drain: enable low only while pulling low
   assign sda_oe_n = sda_o;

   // Array index keeps only the modelled bits; size must be a power of two
   wire [MEM_AW-1:0] mem_idx = cnt_q[MEM_AW-1:0];
   // Byte fetch from array or ID page at current counter
   wire [7:0] rd_byte = id_sel_q ? idp[cnt_q[7:0]]     // [RULE10]
                                 : mem[mem_idx];
   wire       sel_ok  = (sh_q[7:4] == `SRE_TYPE_MEM || sh_q[7:4] == `SRE_TYPE_ID)
                        && sh_q[3] == CHIP_SEL[2];
   wire [17:0] cnt_inc = cnt_q + 18'h0_0001;             // Wraps past top to zero
   // ID page offset wraps inside its page and clears the upper bits
   wire [17:0] cnt_next = id_sel_q ? {10'h000, cnt_q[7:0] + 8'h01} : cnt_inc; // [RULE9]
   // Position of the next data bit, most significant first
   wire [3:0]  nxt_bit  = `SRE_LAST_BIT - 4'h1 - bit_q;

   // Main protocol engine; bit_q counts 0..7 data, 8 = ack slot
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= ST_IDLE;
         bit_q     <= 4'h0;
         sh_q      <= 8'h00;
         dout_q    <= `SRE_ERASED_BYTE;
         cnt_q     <= `SRE_ADDR_ZERO;
         top_q     <= 2'h0;
         id_sel_q  <= 1'b0;
         ack_q     <= 1'b0;
         ack_drv_q <= 1'b0;
         sda_o     <= 1'b1;
      end else if (start_det) begin
         // Any Start aborts a truncated command; address bytes already acked stay loaded in the counter
         st_q  <= ST_DEV;                                // [RULE13]
         // Pre-count: the clock fall that completes the Start is not a data bit
         bit_q <= `SRE_BIT_PRE;
         sda_o <= 1'b1;
         ack_drv_q <= 1'b0;
      end else if (stop_det) begin
         st_q  <= ST_IDLE;                               // [RULE14]
         sda_o <= 1'b1;
         ack_drv_q <= 1'b0;
      end else if (scl_rise && st_q != ST_IDLE) begin
         if (bit_q < `SRE_ACK_SLOT) begin
            sh_q <= {sh_q[6:0], sda_i};
         end else if (st_q == ST_DOUT) begin
            ack_q <= ~sda_i;                             // Master ack sampled in ninth slot
         end
      end else if (scl_fall && st_q != ST_IDLE) begin
         if (bit_q == `SRE_LAST_BIT) begin
            bit_q <= `SRE_ACK_SLOT;
            sda_o <= 1'b1;
            ack_drv_q <= 1'b0;
            case (st_q)
               ST_DEV: begin
                  if (sel_ok) begin
                     sda_o     <= 1'b0;
                     ack_drv_q <= 1'b1;
                     id_sel_q  <= (sh_q[7:4] == `SRE_TYPE_ID);
                     top_q     <= sh_q[2:1];             // [RULE17]
                  end else begin
                     st_q <= ST_IDLE;                    // Not addressed: deselect
                  end
               end
               ST_AHI, ST_ALO: begin
                  sda_o     <= 1'b0;                     // [RULE18]
                  ack_drv_q <= 1'b1;
               end
               ST_DIN: begin
                  // Lock query: data acked only while page unlocked
                  sda_o     <= ~(id_sel_q & ~id_locked); // [RULE12]
                  ack_drv_q <= id_sel_q & ~id_locked;
               end
               default: begin
                  sda_o <= 1'b1;                         // Release for master ack
               end
            endcase
         end else if (bit_q == `SRE_ACK_SLOT) begin
            bit_q <= 4'h0;
            sda_o <= 1'b1;
            ack_drv_q <= 1'b0;
            case (st_q)
               ST_DEV: begin
                  if (sh_q[0]) begin
                     // Read select: drive byte at the shared counter
                     st_q   <= ST_DOUT;                  // [RULE2] [RULE4] [RULE5]
                     dout_q <= rd_byte;
                     sda_o  <= rd_byte[7];
                     cnt_q  <= cnt_next;                 // [RULE9]
                  end else begin
                     st_q <= ST_AHI;
                  end
               end
               ST_AHI: begin
                  // Upper byte ignored for ID page
                  cnt_q[17:8] <= id_sel_q ? 10'h000 : {top_q, sh_q}; // [RULE10] [RULE17]
                  st_q <= ST_ALO;
               end
               ST_ALO: begin
                  cnt_q[7:0] <= sh_q;                    // [RULE18] [RULE1]
                  st_q <= ST_DIN;
               end
               ST_DIN: begin
                  st_q <= ST_DIN;                        // Write data handled elsewhere
               end
               ST_DOUT: begin
                  if (ack_q) begin
                     dout_q <= rd_byte;                  // [RULE7]
                     sda_o  <= rd_byte[7];
                     cnt_q  <= cnt_next;                 // [RULE9]
                  end else begin
                     st_q <= ST_IDLE;                    // [RULE16]
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
         end else begin
            bit_q <= bit_q + 4'h1;
            if (st_q == ST_DOUT)
               sda_o <= dout_q[nxt_bit[2:0]];
            else if (ack_drv_q) begin
               sda_o     <= 1'b1;
               ack_drv_q <= 1'b0;
            end
         end
      end
   end
endmodule // sre_read_engine

// ---- sre_read_engine_chk.sv ----
/*
 Port assertions for the read engine of the two-wire memory target.
 Assumes it is bound to sre_read_engine and sees only its ports.
*/
module sre_read_engine_chk (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_n,
   input wire logic [17:0] addr_cnt
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Drive timing on the open-drain data line
   AST_OE_MATCH: assert property (sda_oe_n == sda_o)
      else $error("enable differs from driven level");
   AST_DRIVE_ON_FALL: assert property (
      $changed(sda_o) |-> !$past(scl_i) && $past(scl_i, 2))
      else $error("data moved off the falling bus clock");
   AST_HOLD_HIGH: assert property (scl_i |=> $stable(sda_o))
      else $error("data moved while bus clock high");
   AST_PULL_LOW: assert property ($fell(sda_o) |-> !scl_i)
      else $error("pull started with bus clock high");
   AST_ACK_HOLD: assert property (
      $fell(sda_o) |-> !sda_o throughout (##[1:40] $fell(scl_i)))
      else $error("low level not held to next clock fall");
   // Conditions leave the line released; a missed release would corrupt them
   AST_STOP_QUIET: assert property (scl_i && $rose(sda_i) |=> sda_o [*8])
      else $error("line pulled after stop");
   AST_START_QUIET: assert property (
      scl_i && $past(scl_i) && $fell(sda_i) |=> sda_o [*8])
      else $error("line pulled after start");
   AST_RESET_IDLE: assert property (
      $rose(rstn) |-> sda_o && addr_cnt == 18'h0_0000)
      else $error("not idle after reset");
   CV_ACK: cover property ($fell(sda_o));
   CV_STOP: cover property (scl_i && $rose(sda_i));
   CV_START: cover property (scl_i && $fell(sda_i));
endmodule // sre_read_engine_chk

bind sre_read_engine sre_read_engine_chk u_chk (.clk, .rstn, .scl_i, .sda_i, .sda_o,
   .sda_oe_n, .addr_cnt);

// ---- sre_master_model.sv ----
/*
 Bus master model for the two-wire link, with bit, byte and condition tasks.
 Assumes the bench resolves the open-drain data wire with a pull-up.
*/
module sre_master_model (
   input  wire logic clk,
   input  wire logic sda_w,
   output logic      scl,
   output logic      sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bus idle with both lines released
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // One third of a bus bit period; moves just after an edge
   task automatic hp;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Start and repeated start; the loaded address is kept with or without a stop before it
   task automatic start;
      sda = 1'b1;
      hp;
      scl = 1'b1;
      hp;
      sda = 1'b0;
      hp;
      scl = 1'b0;
   endtask
   task automatic stop;
      sda = 1'b0;
      hp;
      scl = 1'b1;
      hp;
      sda = 1'b1;
      hp;
   endtask
   // Data set in the low phase, sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      hp;
      sda = b;
      hp;
      scl = 1'b1;
      hp;
      r = sda_w;
      scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic k);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(a, k);
   endtask
endmodule // sre_master_model

// ---- tb_sre_read_engine.sv ----
/*
 Self-checking bench for the read engine: reads, wrap, ID page, lock query.
 Assumes the master model and the bound checker are compiled first.
*/
module tb_sre_read_engine;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        id_locked = 1'b0;
   wire         scl;
   wire         sda_m;
   wire         sda_o;
   wire         sda_oe_n;
   wire  [17:0] addr_cnt;
   wire         sda_w = sda_m & (sda_oe_n | sda_o); // Pull-up wire
   int          err_count = 0;
   int          checked = 0;
   logic  [7:0] q;
   logic        k;
   always #5 clk = ~clk;
   sre_master_model bus (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda_m));
   sre_read_engine DUT (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .id_locked(id_locked), .addr_cnt(addr_cnt));
   task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Select byte: chip bit zero, top address bits, direction
   function automatic logic [7:0] sel(input logic [3:0] t, input logic [17:0] a, input logic r);
      return {t, 1'b0, a[17:16], r};
   endfunction
   // Dummy write loading the counter, MSB byte first
   task automatic load(input logic [3:0] t, input logic [17:0] a);
      bus.start;
      bus.xfer(sel(t, a, 1'b0), 1'b1, q, k);
      chk("sel ack", 18'(k), 18'h0_0000);
      bus.xfer(a[15:8], 1'b1, q, k);
      chk("hi ack", 18'(k), 18'h0_0000);
      bus.xfer(a[7:0], 1'b1, q, k);
      chk("lo ack", 18'(k), 18'h0_0000);
   endtask
   // Read select then n erased bytes, all acked but the last
   task automatic rd(input logic [3:0] t, input logic [17:0] a, input int n);
      bus.start;
      bus.xfer(sel(t, a, 1'b1), 1'b1, q, k);
      chk("rd sel ack", 18'(k), 18'h0_0000);
      for (int i = 1; i <= n; i++) begin
         bus.xfer(8'hff, i == n, q, k);
         chk("rd data", 18'(q), 18'h0_00ff);
      end
      bus.stop;
   endtask
   task automatic t_wrap;
      load(4'ha, 18'h3_ffff);
      bus.hp; // Low byte lands on the clock fall that ends the ack slot
      chk("loaded", addr_cnt, 18'h3_ffff);
      rd(4'ha, 18'h3_ffff, 2);
      chk("wrap", addr_cnt, 18'h0_0001);
   endtask
   // Upper bits of an ID page address are ignored; three bytes stay in the page
   task automatic t_current;
      rd(4'ha, 18'h0_0000, 1);
      chk("current", addr_cnt, 18'h0_0002);
      load(4'hb, 18'h2_ff64);
      rd(4'hb, 18'h2_ff64, 3);
      chk("id offset", addr_cnt, 18'h0_0067);
      rd(4'ha, 18'h0_0000, 1);
      chk("after id", addr_cnt, 18'h0_0068);
   endtask
   task automatic t_lock;
      for (int l = 0; l < 2; l++) begin
         id_locked = l[0];
         load(4'hb, 18'h0_0010);
         bus.xfer(8'h00, 1'b1, q, k);
         chk("lock ack", 18'(k), 18'(l[0]));
         bus.start;
         bus.stop;
      end
      rd(4'ha, 18'h0_0000, 1);
   endtask
   // Foreign type code and wrong chip bit go unanswered
   task automatic t_foreign;
      for (int i = 0; i < 2; i++) begin
         bus.start;
         bus.xfer(i ? 8'ha9 : 8'h51, 1'b1, q, k);
         chk("foreign", 18'(k), 18'h0_0001);
         bus.stop;
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (4) @(posedge clk);
      t_wrap;
      t_current;
      t_lock;
      t_foreign;
      end_of_test;
   end
   // Watchdog against a hung sequence
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      end_of_test;
   end
endmodule // tb_sre_read_engine
